// ===== logic/scbc_core.sv
// Strap capture, basic mode control and indirect register access
`default_nettype none
// Functional notes
// - Station address latched at power-up and hardware reset, held until next one.
// - Sixteen station addresses 0..15; upper address bit always zero.
// - No pull-ups fitted gives station address zero.
// - Level 1,2,3,4 decode to bit pairs 00, 01, 11, 10.
// - Valid pin gives addr 0,2; error pin addr 1,3; data pins interface and test.
// - Interface select codes: reserved, MII, RMII two kinds, four RGMII delay kinds.
// - Test select: normal, modes 1,2,4,5; codes 3,6,7 reserved.
// - Role strap bit 0 follower, 1 leader; board uses levels 1 or 4.
// - Autonomous bit 0 starts link alone; 1 waits for register enable.
// - Autonomous strap only matters for leader; follower ignores it.
// - Indicator drive polarity follows the level sampled at reset.
// - Only addresses 0x0..0x1F reachable directly; rest only indirectly.
// - Vendor space 0x20..0xFFF, device-1 0x0..0xFFF; direct registers also via vendor.
// - Control bit 15 resets PCS registers, reads 1 while running, self-clears.
// - Bit 14 loops MAC transmit onto receive and suppresses link indication.
// - Bit 13 read-only, always 1 for fixed 100 Mb/s.
// - Latched-high holds 1, latched-low holds 0 until read; strap fields from strap.
// - Straps sampled at power-up and any hardware reset, pin or register.
// - Bit 11 power-down ORed with active-low pin; only registers stay alive.
// - Function code 00 targets address pointer; otherwise the pointed register.
module scbc_core
  import scbc_pkg::*;
#(
  parameter int EXT_AW = 12
) (
  // Clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST,
  // Strap levels
  input  wire scbc_pkg::scbc_strap_lvl_t STRAP_LVL,
  // Management register access
  input  wire logic [4:0]                MGMT_PHYAD,
  input  wire logic [4:0]                MGMT_ADDR,
  input  wire logic                      MGMT_WR,
  input  wire logic                      MGMT_RD,
  input  wire logic [15:0]               MGMT_WDATA,
  output logic      [15:0]               MGMT_RDATA,
  output logic                           MGMT_RVALID,
  // MAC side data
  input  wire logic [3:0]                MAC_TXD,
  input  wire logic                      MAC_TX_EN,
  input  wire logic [3:0]                PCS_RXD,
  input  wire logic                      PCS_RX_DV,
  output logic      [3:0]                MAC_RXD,
  output logic                           MAC_RX_DV,
  // Link control and status
  input  wire logic                      LINK_OK,
  input  wire logic                      JABBER_DET,
  output logic                           LINK_IND,
  output logic                           LINK_START,
  // Power and reset
  input  wire logic                      INT_PWDN_N,
  output logic                           PWR_DOWN,
  output logic                           PCS_RST,
  output logic                           ISOLATE,
  // Decoded configuration
  output scbc_pkg::scbc_cfg_t            CFG,
  output logic      [2:0]                TEST_MODE,
  // Indicator pins
  input  wire logic [1:0]                LED_ON,
  output logic                           INDICATOR0_O,
  output logic                           INDICATOR0_OE,
  output logic                           INDICATOR1_O,
  output logic                           INDICATOR1_OE
);

  scbc_core_st_t s_q;
  scbc_core_st_t s_d;
  scbc_cfg_t     dec_cfg;
  logic [15:0]   mem_rdata;
  logic          acc;
  logic          ind;
  logic          vend;
  logic          dev1;
  logic          ind_direct;
  logic          ind_mem;
  logic [4:0]    eff_addr;
  logic          eff_wr;
  logic          eff_rd;
  logic          link_now;
  logic          mem_we;
  logic [EXT_AW:0] mem_addr;

  scbc_strap_dec u_dec (
    .lvl (STRAP_LVL),
    .cfg (dec_cfg)
  );

  scbc_ext_mem #(
    .AW (EXT_AW + 1),
    .DW (16)
  ) u_mem (
    .clk   (CLK_SYS),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (MGMT_WDATA),
    .rdata (mem_rdata)
  );

  // Read value of a direct register
  function automatic logic [15:0] rd_direct(input logic [4:0] a, input scbc_core_st_t s);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      // busy flag and fixed speed bit
      BMC_OFF: begin
        v = {(s.st == SCBC_SRST), s.loopback, 1'b1, 1'b0, s.pwdn, s.isolate, BMC_RSVD_VAL};
      end
      BMS_OFF: begin
        v = BMS_FIXED_VAL | {13'h0000, s.link_ll, s.jab_lh, 1'b0};
      end
      IND_CTRL_OFF: begin
        v = {s.ind_fn, 9'h000, s.ind_devad};
      end
      IND_AD_OFF: begin
        v = s.ptr;
      end
      STRAP_STAT_OFF: begin
        v = {2'h0, s.cfg.if_valid, s.cfg.test_valid, s.cfg.managed_start, s.cfg.lead_follow_role,
             s.cfg.test_select, s.cfg.host_if_select, s.cfg.station_addr_strap[3:0]};
      end
      MGMT_CTRL_OFF: begin
        v = {15'h0000, s.link_en};
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction

  // Address decode of the current access
  always_comb begin
    // answer only at the latched address
    acc  = (MGMT_PHYAD == s_q.cfg.station_addr_strap) && (s_q.st != SCBC_SAMPLE);
    // data function targets the pointed register
    ind  = acc && (MGMT_ADDR == IND_AD_OFF) && (s_q.ind_fn != FN_ADDR);
    vend = (s_q.ind_devad == DEVAD_VENDOR);
    dev1 = (s_q.ind_devad == DEVAD_DEV1);
    // vendor low range maps onto the direct registers
    ind_direct = ind && vend && (s_q.ptr < VENDOR_LO);
    ind_mem    = ind && ((vend && (s_q.ptr >= VENDOR_LO) && (s_q.ptr <= SPACE_HI)) ||
                         (dev1 && (s_q.ptr <= SPACE_HI)));
    eff_addr = ind_direct ? s_q.ptr[4:0] : MGMT_ADDR;
    eff_wr   = acc && MGMT_WR && (!ind || ind_direct);
    eff_rd   = acc && MGMT_RD && (!ind || ind_direct);
    mem_we   = ind_mem && MGMT_WR;
    mem_addr = {dev1, s_q.ptr[EXT_AW-1:0]};
    // no link indication in loopback or power-down
    link_now = LINK_OK && !s_q.loopback && !s_q.pwdn;
  end

  // Next state
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    s_d.rd_mem = 1'b0;
    case (s_q.st)
      // capture straps once after hardware reset
      SCBC_SAMPLE: begin
        s_d.cfg = dec_cfg;
        s_d.st  = SCBC_RUN;
      end
      SCBC_RUN: begin
        s_d.st = SCBC_RUN;
      end
      SCBC_SRST: begin
        s_d.srst_cnt = 8'(s_q.srst_cnt - 8'h01);
        if (s_q.srst_cnt == 8'h01) begin
          s_d.st = SCBC_RUN;
        end
      end
      default: begin
        s_d.st = SCBC_SAMPLE;
      end
    endcase

    if (acc && MGMT_RD) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = eff_rd ? rd_direct(eff_addr, s_q) : 16'h0000;
      s_d.rd_mem = ind_mem;
    end

    // latch clears on read, a new event wins
    s_d.link_ll = ((eff_rd && (eff_addr == BMS_OFF)) ? 1'b1 : s_q.link_ll) & link_now;
    s_d.jab_lh  = ((eff_rd && (eff_addr == BMS_OFF)) ? 1'b0 : s_q.jab_lh) | JABBER_DET;

    if (eff_wr) begin
      case (eff_addr)
        BMC_OFF: begin
          if (MGMT_WDATA[BMC_RST_BIT]) begin
            // PCS registers cleared, vendor state kept
            s_d.st       = SCBC_SRST;
            s_d.srst_cnt = SRST_CYC;
            s_d.loopback = 1'b0;
            s_d.pwdn     = 1'b0;
            s_d.isolate  = 1'b0;
            s_d.link_ll  = 1'b0;
            // Jabber event in the same cycle wins
            s_d.jab_lh   = JABBER_DET;
          end else begin
            s_d.loopback = MGMT_WDATA[BMC_LOOP_BIT];
            s_d.pwdn     = MGMT_WDATA[BMC_PWDN_BIT];
            s_d.isolate  = MGMT_WDATA[BMC_ISO_BIT];
          end
        end
        IND_CTRL_OFF: begin
          s_d.ind_fn    = MGMT_WDATA[15:14];
          s_d.ind_devad = MGMT_WDATA[4:0];
        end
        IND_AD_OFF: begin
          s_d.ptr = MGMT_WDATA;
        end
        MGMT_CTRL_OFF: begin
          s_d.link_en = MGMT_WDATA[MGMT_LINKEN_BIT];
        end
        default: begin
          s_d.link_en = s_q.link_en;
        end
      endcase
    end

    // Post increment of the pointer
    if (ind && ((s_q.ind_fn == FN_INC_RW && (MGMT_RD || MGMT_WR)) || (s_q.ind_fn == FN_INC_W && MGMT_WR))) begin
      s_d.ptr = 16'(s_q.ptr + 16'h0001);
    end

    if (!INT_PWDN_N) begin
      s_d.pwdn = 1'b1;
    end

    // loop transmit back, or quiet in power-down
    if (s_q.pwdn || s_q.isolate) begin
      s_d.mac_rxd  = 4'h0;
      s_d.mac_rxdv = 1'b0;
    end else if (s_q.loopback) begin
      s_d.mac_rxd  = MAC_TXD;
      s_d.mac_rxdv = MAC_TX_EN;
    end else begin
      s_d.mac_rxd  = PCS_RXD;
      s_d.mac_rxdv = PCS_RX_DV;
    end

    if (eff_wr && (eff_addr == MGMT_CTRL_OFF) && MGMT_WDATA[MGMT_HWRST_BIT]) begin
      s_d = SCBC_CORE_RST;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q <= SCBC_CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign MGMT_RDATA  = s_q.rd_mem ? mem_rdata : s_q.rdata;
  assign MGMT_RVALID = s_q.rvalid;
  assign MAC_RXD     = s_q.mac_rxd;
  assign MAC_RX_DV   = s_q.mac_rxdv;
  assign LINK_IND    = s_q.link_ll && link_now;
  // leader in managed mode waits for enable
  assign LINK_START  = (s_q.st == SCBC_RUN) && !PWR_DOWN && !s_q.loopback &&
                       (!s_q.cfg.lead_follow_role || !s_q.cfg.managed_start || s_q.link_en);
  assign PWR_DOWN    = s_q.pwdn || !INT_PWDN_N;
  assign PCS_RST     = (s_q.st == SCBC_SRST);
  assign ISOLATE     = s_q.isolate;
  assign CFG         = s_q.cfg;
  // reserved test code runs as normal operation
  assign TEST_MODE   = s_q.cfg.test_valid ? s_q.cfg.test_select : 3'h0;
  assign INDICATOR0_O  = LED_ON[0] ^ s_q.cfg.led0_pol;
  assign INDICATOR1_O  = LED_ON[1] ^ s_q.cfg.led1_pol;
  assign INDICATOR0_OE = (s_q.st != SCBC_SAMPLE) && !RST;
  assign INDICATOR1_OE = (s_q.st != SCBC_SAMPLE) && !RST;

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_addr_upper_zero: assert property (CFG.station_addr_strap[4] == 1'b0)
    else $error("station address upper bit set");
  a_strap_held: assert property ((s_q.st == SCBC_RUN) && !(eff_wr && eff_addr == MGMT_CTRL_OFF) |=>
                                 $stable(CFG))
    else $error("strap configuration changed without hardware reset");
  a_sample_once: assert property ((s_q.st == SCBC_SAMPLE) |=> (s_q.st == SCBC_RUN) &&
                                  (CFG == $past(dec_cfg)))
    else $error("straps not captured after reset");
  a_soft_reset_len: assert property ($rose(PCS_RST) |-> PCS_RST [*8] ##17 PCS_RST ##1 !PCS_RST)
    else $error("soft reset length wrong");
  a_speed_bit_one: assert property (eff_rd && (eff_addr == BMC_OFF) |=> MGMT_RVALID && MGMT_RDATA[13])
    else $error("speed bit not read as one");
  a_loop_data: assert property (s_q.loopback && !s_q.pwdn && !s_q.isolate |=>
                                (MAC_RXD == $past(MAC_TXD)) && (MAC_RX_DV == $past(MAC_TX_EN)))
    else $error("loopback data mismatch");
  a_loop_nolink: assert property (s_q.loopback |-> !LINK_IND)
    else $error("link indicated in loopback");
  a_pwdn_pin: assert property (!INT_PWDN_N |-> PWR_DOWN ##1 s_q.pwdn)
    else $error("power-down pin not honoured");
  a_pwdn_quiet: assert property (s_q.pwdn |=> (MAC_RXD == 4'h0) && !MAC_RX_DV)
    else $error("receive data not quiet in power-down");
  a_follower_start: assert property ((s_q.st == SCBC_RUN) && !CFG.lead_follow_role && !PWR_DOWN &&
                                     !s_q.loopback |-> LINK_START)
    else $error("follower not starting link");
  a_managed_hold: assert property (CFG.lead_follow_role && CFG.managed_start && !s_q.link_en |->
                                   !LINK_START)
    else $error("managed leader started link without enable");
  a_jabber_hold: assert property (JABBER_DET |=> s_q.jab_lh)
    else $error("latched-high bit lost");
  a_test_safe: assert property (!CFG.test_valid |-> (TEST_MODE == 3'h0))
    else $error("reserved test code applied");
  a_ind_target: assert property (acc && MGMT_WR && (MGMT_ADDR == IND_AD_OFF) && (s_q.ind_fn == FN_ADDR) |=>
                                 (s_q.ptr == $past(MGMT_WDATA)))
    else $error("pointer not written in address function");

  c_soft_reset: cover property ($fell(PCS_RST));
  c_pin_pwdn: cover property ($fell(INT_PWDN_N));
  c_loopback: cover property (s_q.loopback && MAC_TX_EN ##1 MAC_RX_DV);
  c_ind_mem_read: cover property (ind_mem && MGMT_RD ##1 MGMT_RVALID);
  c_managed_start: cover property (CFG.managed_start && CFG.lead_follow_role && $rose(LINK_START));

endmodule
`default_nettype wire

// ===== logic/scbc_ext_mem.sv
// Storage for the extended register spaces, registered read
`default_nettype none
module scbc_ext_mem #(
  parameter int AW = 13,
  parameter int DW = 16
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
`default_nettype wire

// ===== logic/scbc_pkg.sv
// Shared constants and types for the strap loader and basic control block
`default_nettype none
package scbc_pkg;

  // Direct register offsets
  localparam logic [4:0]  BMC_OFF        = 5'h00;
  localparam logic [4:0]  BMS_OFF        = 5'h01;
  localparam logic [4:0]  IND_CTRL_OFF   = 5'h0D;
  localparam logic [4:0]  IND_AD_OFF     = 5'h0E;
  localparam logic [4:0]  STRAP_STAT_OFF = 5'h1E;
  localparam logic [4:0]  MGMT_CTRL_OFF  = 5'h1F;

  // Basic mode control bit positions and fixed read values
  localparam int          BMC_RST_BIT    = 15;
  localparam int          BMC_LOOP_BIT   = 14;
  localparam int          BMC_SPEED_BIT  = 13;
  localparam int          BMC_PWDN_BIT   = 11;
  localparam int          BMC_ISO_BIT    = 10;
  localparam logic [9:0]  BMC_RSVD_VAL   = 10'h100;
  localparam logic [15:0] BMS_FIXED_VAL  = 16'h0061;
  localparam int          MGMT_HWRST_BIT = 15;
  localparam int          MGMT_LINKEN_BIT = 0;

  // Indirect access
  localparam logic [1:0]  FN_ADDR        = 2'h0;
  localparam logic [1:0]  FN_DATA        = 2'h1;
  localparam logic [1:0]  FN_INC_RW      = 2'h2;
  localparam logic [1:0]  FN_INC_W       = 2'h3;
  localparam logic [4:0]  DEVAD_VENDOR   = 5'h1F;
  localparam logic [4:0]  DEVAD_DEV1     = 5'h01;
  localparam logic [15:0] VENDOR_LO      = 16'h0020;
  localparam logic [15:0] SPACE_HI       = 16'h0FFF;

  // Soft reset duration
  localparam int          CLK_FREQ_MHZ   = 25;
  localparam int          SRST_TIME_NS   = 1000;
  localparam logic [7:0]  SRST_CYC       = 8'((SRST_TIME_NS * CLK_FREQ_MHZ + 999) / 1000);

  // Test select and interface select codes that are reserved
  localparam logic [2:0]  TEST_RSV_A     = 3'h3;
  localparam logic [2:0]  TEST_RSV_B     = 3'h6;
  localparam logic [2:0]  TEST_RSV_C     = 3'h7;
  localparam logic [2:0]  IF_RSV         = 3'h0;

  typedef enum logic [1:0] {
    SCBC_SAMPLE = 2'h0,
    SCBC_RUN    = 2'h1,
    SCBC_SRST   = 2'h3
  } scbc_state_t;

  // Strap levels: 0..3 stand for level 1..4
  typedef struct packed {
    logic [1:0] rxdv;
    logic [1:0] rxer;
    logic [1:0] rxd0;
    logic [1:0] rxd1;
    logic [1:0] rxd2;
    logic [1:0] rxd3;
    logic [1:0] led0;
    logic [1:0] led1;
  } scbc_strap_lvl_t;

  typedef struct packed {
    logic [4:0] station_addr_strap;
    logic [2:0] host_if_select;
    logic [2:0] test_select;
    logic       lead_follow_role;
    logic       managed_start;
    logic       led0_pol;
    logic       led1_pol;
    logic       if_valid;
    logic       test_valid;
  } scbc_cfg_t;

  typedef struct packed {
    scbc_state_t st;
    scbc_cfg_t   cfg;
    logic [7:0]  srst_cnt;
    logic        loopback;
    logic        pwdn;
    logic        isolate;
    logic        link_ll;
    logic        jab_lh;
    logic [1:0]  ind_fn;
    logic [4:0]  ind_devad;
    logic [15:0] ptr;
    logic        link_en;
    logic [15:0] rdata;
    logic        rvalid;
    logic        rd_mem;
    logic [3:0]  mac_rxd;
    logic        mac_rxdv;
  } scbc_core_st_t;

  // All-zero: sample state, address zero, controls off
  localparam scbc_core_st_t SCBC_CORE_RST = '0;

endpackage
`default_nettype wire

// ===== logic/scbc_strap_dec.sv
// Decodes four-level strap pins into configuration fields
`default_nettype none
module scbc_strap_dec
  import scbc_pkg::*;
(
  // Raw strap levels
  input  wire scbc_pkg::scbc_strap_lvl_t lvl,
  // Decoded configuration
  output scbc_pkg::scbc_cfg_t            cfg
);

  // Level to {first, second}
  function automatic logic [1:0] lvl_bits(input logic [1:0] l);
    lvl_bits = {l[1], l[1] ^ l[0]};
  endfunction

  logic [1:0] dv_b;
  logic [1:0] er_b;
  logic [1:0] d0_b;
  logic [1:0] d1_b;
  logic [1:0] d2_b;
  logic [1:0] l0_b;
  logic [1:0] l1_b;

  assign dv_b = lvl_bits(lvl.rxdv);
  assign er_b = lvl_bits(lvl.rxer);
  assign d0_b = lvl_bits(lvl.rxd0);
  assign d1_b = lvl_bits(lvl.rxd1);
  assign d2_b = lvl_bits(lvl.rxd2);
  assign l0_b = lvl_bits(lvl.led0);
  assign l1_b = lvl_bits(lvl.led1);

  always_comb begin
    // bit assignment, upper address bit zero
    cfg.station_addr_strap = {1'b0, er_b[0], dv_b[0], er_b[1], dv_b[1]};
    cfg.host_if_select     = {d2_b[1], d1_b[1], d0_b[1]};
    cfg.test_select        = {d2_b[0], d1_b[0], d0_b[0]};
    cfg.lead_follow_role   = l0_b[1];
    cfg.managed_start      = l1_b[1];
    cfg.led0_pol           = l0_b[1];
    cfg.led1_pol           = l1_b[1];
    cfg.if_valid           = (cfg.host_if_select != IF_RSV);
    cfg.test_valid         = (cfg.test_select != TEST_RSV_A) && (cfg.test_select != TEST_RSV_B) &&
                             (cfg.test_select != TEST_RSV_C);
  end

endmodule
`default_nettype wire

// ===== test/scbc_mgmt_model.sv
// Management controller model that drives the register strobes
`default_nettype none
module scbc_mgmt_model
  import scbc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register strobes
  output logic      [4:0]  phyad,
  output logic      [4:0]  addr,
  output logic             wr,
  output logic             rd,
  output logic      [15:0] wdata,
  // Answer
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    phyad = 5'h00;
    addr  = 5'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    wdata = 16'h0000;
  end

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
    wdata = ~d;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    v    = rvalid;
    d    = rdata;
    rd   = 1'b0;
  endtask

  task automatic ext_set(input logic [4:0] dev, input logic [15:0] a);
    wr_reg(IND_CTRL_OFF, {11'h000, dev});
    wr_reg(IND_AD_OFF, a);
    wr_reg(IND_CTRL_OFF, {FN_DATA, 9'h000, dev});
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for strap capture and basic control
`default_nettype none
module testbench;
  import scbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk_sys, rst, mac_tx_en, pcs_rx_dv, link_ok, jabber_det, int_pwdn_n;
  logic            rvalid, mac_rx_dv, link_ind, link_start, pwr_down, pcs_rst, wr, rd;
  logic            ind0_o, ind0_oe, ind1_o, ind1_oe, rd_v, isolate;
  logic [1:0]      led_on;
  logic [2:0]      test_mode;
  logic [3:0]      mac_txd, pcs_rxd, mac_rxd;
  logic [4:0]      phyad, addr;
  logic [15:0]     wdata, rdata, rd_d;
  scbc_strap_lvl_t strap_lvl;
  scbc_cfg_t       cfg;
  int              err_total, compares;

  scbc_core uut (
    .CLK_SYS(clk_sys), .RST(rst), .STRAP_LVL(strap_lvl), .MGMT_PHYAD(phyad), .MGMT_ADDR(addr),
    .MGMT_WR(wr), .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .MGMT_RVALID(rvalid),
    .MAC_TXD(mac_txd), .MAC_TX_EN(mac_tx_en), .PCS_RXD(pcs_rxd), .PCS_RX_DV(pcs_rx_dv),
    .MAC_RXD(mac_rxd), .MAC_RX_DV(mac_rx_dv), .LINK_OK(link_ok), .JABBER_DET(jabber_det),
    .LINK_IND(link_ind), .LINK_START(link_start), .INT_PWDN_N(int_pwdn_n), .PWR_DOWN(pwr_down),
    .PCS_RST(pcs_rst), .ISOLATE(isolate), .CFG(cfg), .TEST_MODE(test_mode), .LED_ON(led_on),
    .INDICATOR0_O(ind0_o), .INDICATOR0_OE(ind0_oe), .INDICATOR1_O(ind1_o), .INDICATOR1_OE(ind1_oe)
  );

  scbc_mgmt_model mgr (
    .clk(clk_sys), .phyad(phyad), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic scbc_strap_lvl_t mk(input logic [3:0] a, input logic [2:0] f, input logic [2:0] t,
                                         input logic r, input logic m);
    return {a[0], a[0] ^ a[2], a[1], a[1] ^ a[3], f[0], f[0] ^ t[0], f[1], f[1] ^ t[1],
            f[2], f[2] ^ t[2], 2'b00, r, r, m, m};
  endfunction

  task automatic boot(input scbc_strap_lvl_t s, input logic [3:0] a);
    @(negedge clk_sys);
    rst       = 1'b1;
    strap_lvl = s;
    repeat (10) @(negedge clk_sys);
    rst       = 1'b0;
    mgr.phyad = {1'b0, a};
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic t_strap;
    logic [3:0] a;
    logic [2:0] f;
    logic [2:0] t;
    logic       r;
    logic       m;
    logic       tv;
    for (int k = 0; k < 8; k++) begin
      a  = 4'(k * 2 + k % 2);
      f  = 3'(k);
      t  = 3'(k * 3);
      r  = k[0];
      m  = k[1];
      tv = !(t inside {3'h3, 3'h6, 3'h7});
      boot(mk(a, f, t, r, m), a);
      chk(16'(cfg.station_addr_strap), 16'(a), "addr");
      chk(16'(cfg.host_if_select), 16'(f), "if sel");
      chk(16'(cfg.test_select), 16'(t), "test sel");
      chk(16'(test_mode), tv ? 16'(t) : 16'h0000, "test mode");
      chk(16'(cfg.lead_follow_role), 16'(r), "role");
      chk(16'(link_start), 16'(!r || !m), "start");
      chk(16'({ind0_oe, ind0_o, ind1_oe, ind1_o}), 16'({1'b1, ~r, 1'b1, ~m}), "led");
      mgr.rd_reg(STRAP_STAT_OFF, rd_d, rd_v);
      chk(rd_d, {2'b00, f != 3'h0, tv, m, r, t, f, a}, "strap status");
      strap_lvl = ~strap_lvl;
      @(negedge clk_sys);
      chk(16'(cfg.station_addr_strap), 16'(a), "addr held");
    end
    $display("test strap done");
  endtask

  task automatic t_bmc;
    boot(mk(4'h5, 3'h1, 3'h0, 1'b1, 1'b1), 4'h5);
    chk(16'(link_start), 16'h0000, "managed hold");
    mgr.wr_reg(MGMT_CTRL_OFF, 16'h0001);
    chk(16'(link_start), 16'h0001, "managed start");
    mgr.rd_reg(BMC_OFF, rd_d, rd_v);
    chk(rd_d, 16'h2100, "bmc reset");
    mgr.wr_reg(BMC_OFF, 16'h4000);
    mac_txd   = 4'hA;
    mac_tx_en = 1'b1;
    link_ok   = 1'b1;
    @(negedge clk_sys);
    chk(16'({mac_rx_dv, mac_rxd}), 16'h001A, "loop data");
    chk(16'({link_ind, link_start}), 16'h0000, "loop link");
    mgr.rd_reg(BMC_OFF, rd_d, rd_v);
    chk(rd_d, 16'h6100, "bmc loop");
    mgr.wr_reg(BMC_OFF, 16'h8000);
    chk(16'(pcs_rst), 16'h0001, "pcs reset");
    mgr.rd_reg(BMC_OFF, rd_d, rd_v);
    chk(16'(rd_d[15]), 16'h0001, "reset busy");
    repeat (30) @(negedge clk_sys);
    mgr.rd_reg(BMC_OFF, rd_d, rd_v);
    chk(rd_d, 16'h2100, "reset done");
    chk(16'({pcs_rst, link_start}), 16'h0001, "vendor kept");
    int_pwdn_n = 1'b0;
    @(negedge clk_sys);
    chk(16'({pwr_down, link_start}), 16'h0002, "pin pwdn");
    mgr.rd_reg(BMC_OFF, rd_d, rd_v);
    chk(16'(rd_v), 16'h0001, "regs alive");
    int_pwdn_n = 1'b1;
    mgr.wr_reg(BMC_OFF, 16'h0800);
    chk(16'(pwr_down), 16'h0001, "bit pwdn");
    mgr.wr_reg(BMC_OFF, 16'h0000);
    chk(16'(pwr_down), 16'h0000, "pwdn off");
    mgr.wr_reg(BMC_OFF, 16'h0400);
    @(negedge clk_sys);
    chk(16'({isolate, mac_rx_dv, mac_rxd}), 16'h0020, "isolate");
    mgr.wr_reg(BMC_OFF, 16'h0000);
    @(negedge clk_sys);
    chk(16'({isolate, mac_rx_dv, mac_rxd}), 16'h0015, "pcs path");
    jabber_det = 1'b1;
    @(negedge clk_sys);
    jabber_det = 1'b0;
    mgr.rd_reg(BMS_OFF, rd_d, rd_v);
    chk(rd_d & 16'hFFFB, 16'h0063, "jabber held");
    mgr.rd_reg(BMS_OFF, rd_d, rd_v);
    chk(rd_d & 16'hFFFB, 16'h0061, "jabber read");
    chk(16'(link_ind), 16'h0001, "link ind");
    $display("test bmc done");
  endtask

  task automatic t_ind;
    mgr.ext_set(DEVAD_VENDOR, 16'h0462);
    mgr.wr_reg(IND_AD_OFF, 16'hBEEF);
    mgr.rd_reg(IND_AD_OFF, rd_d, rd_v);
    chk(rd_d, 16'hBEEF, "vendor word");
    mgr.ext_set(DEVAD_DEV1, 16'h0007);
    mgr.wr_reg(IND_AD_OFF, 16'h1234);
    mgr.rd_reg(IND_AD_OFF, rd_d, rd_v);
    chk(rd_d, 16'h1234, "dev1 word");
    mgr.ext_set(DEVAD_VENDOR, 16'h0000);
    mgr.rd_reg(IND_AD_OFF, rd_d, rd_v);
    chk(rd_d, 16'h2100, "vendor alias");
    mgr.ext_set(DEVAD_VENDOR, 16'h1000);
    mgr.rd_reg(IND_AD_OFF, rd_d, rd_v);
    chk({rd_d[14:0], rd_v}, 16'h0001, "out of range");
    mgr.rd_reg(5'h05, rd_d, rd_v);
    chk({rd_d[14:0], rd_v}, 16'h0001, "unmapped");
    mgr.phyad = 5'h06;
    mgr.rd_reg(BMC_OFF, rd_d, rd_v);
    chk(16'(rd_v), 16'h0000, "other station");
    mgr.phyad = 5'h05;
    strap_lvl = mk(4'hC, 3'h1, 3'h0, 1'b0, 1'b0);
    mgr.wr_reg(MGMT_CTRL_OFF, 16'h8000);
    repeat (3) @(negedge clk_sys);
    chk(16'(cfg.station_addr_strap), 16'h000C, "hw reset resample");
    $display("test indirect done");
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end

  initial begin
    err_total  = 0;
    compares   = 0;
    rst        = 1'b1;
    strap_lvl  = '0;
    mac_txd    = 4'h0;
    mac_tx_en  = 1'b0;
    pcs_rxd    = 4'h5;
    pcs_rx_dv  = 1'b1;
    link_ok    = 1'b0;
    jabber_det = 1'b0;
    int_pwdn_n = 1'b1;
    led_on     = 2'b11;
    t_strap();
    t_bmc();
    t_ind();
    end_of_test();
  end
endmodule
`default_nettype wire
